// File: dsoc_ctrl.sv
/*
  output-state and clocking control for the receive side of a serial link:
  spread modulation, power-down, stream-stop sleep, lock sequence, output
  state selection and fallback oscillator. assumes stream_present_i comes
  from clock recovery, already synchronous to clk_i.
*/
`default_nettype none
`include "dsoc_defs.svh"
module dsoc_ctrl (
  input  wire logic                 clk_i,
  input  wire logic                 rst_b_i,
  input  wire logic                 power_down_bar_i,
  input  wire logic                 stream_present_i,
  input  wire logic                 rec_clk_i,
  input  wire dsoc_pkg::dsoc_word_s rec_word_i,
  input  wire logic                 rec_valid_i,
  output logic                      rec_ready_o,
  input  wire dsoc_pkg::dsoc_cfg_s  strap_cfg_i,
  input  wire dsoc_pkg::dsoc_cfg_s  sw_cfg_i,
  input  wire logic                 sw_cfg_wr_i,
  input  wire logic                 out_ready_i,
  output logic                      recovered_clock_out_o,
  output logic                      recovered_clock_out_oe_b_o,
  output dsoc_pkg::dsoc_word_s      par_out_o,
  output logic                      par_out_oe_b_o,
  output logic                      par_valid_o,
  output logic                      lock_o,
  output logic                      lock_oe_b_o,
  output logic                      test_pass_o,
  output logic                      test_pass_oe_b_o,
  output logic                      mod_enable_o,
  output logic [3:0]                mod_dev_o,
  output logic                      mod_tick_o
);
  //////////////////////////////////////////////////////////////////////////
  dsoc_pkg::dsoc_state_e state_reg;
  dsoc_pkg::dsoc_state_e state_next;
  dsoc_pkg::dsoc_cfg_s   sw_cfg_reg;
  logic                  sw_written_reg;
  dsoc_pkg::dsoc_cfg_s   cfg;
  logic [9:0]            acq_cnt_reg;
  logic [15:0]           mod_cnt_reg;
  logic [15:0]           mod_period;
  logic [7:0]            osc_cnt_reg;
  logic                  osc_reg;
  logic                  osc_active;
  logic                  clk_src_osc_reg;
  logic                  clk_lvl;
  dsoc_pkg::dsoc_word_s  buf_word;
  logic                  buf_valid;
  logic                  buf_ready;
  logic                  buf_push;
  logic                  buf_pop;
  logic                  rec_room_next;

  localparam logic [9:0] ACQ_CYC = 10'(`DSOC_ACQ_CYC);

  function automatic logic [15:0] mod_div(input logic [3:0] code, input logic lf);
    logic [1:0] grp;
    grp = 2'((code - 4'h1) >> 2);
    if (lf) begin
      case (grp)
        2'h0:    mod_div = `DSOC_MOD_LO_0;
        2'h1:    mod_div = `DSOC_MOD_LO_1;
        2'h2:    mod_div = `DSOC_MOD_LO_2;
        default: mod_div = `DSOC_MOD_LO_3;
      endcase
    end else begin
      case (grp)
        2'h0:    mod_div = `DSOC_MOD_HI_0;
        2'h1:    mod_div = `DSOC_MOD_HI_1;
        2'h2:    mod_div = `DSOC_MOD_HI_2;
        default: mod_div = `DSOC_MOD_HI_3;
      endcase
    end
  endfunction

  function automatic logic [3:0] mod_step(input logic [3:0] code);
    case (2'(code - 4'h1))
      2'h0:    mod_step = `DSOC_DEV_0;
      2'h1:    mod_step = `DSOC_DEV_1;
      2'h2:    mod_step = `DSOC_DEV_2;
      default: mod_step = `DSOC_DEV_3;
    endcase
  endfunction

  function automatic logic [7:0] osc_half(input logic [2:0] sel);
    case (sel)
      3'h1:    osc_half = `DSOC_OSC_HP_1;
      3'h2:    osc_half = `DSOC_OSC_HP_2;
      3'h3:    osc_half = `DSOC_OSC_HP_3;
      3'h4:    osc_half = `DSOC_OSC_HP_4;
      3'h5:    osc_half = `DSOC_OSC_HP_5;
      3'h6:    osc_half = `DSOC_OSC_HP_6;
      default: osc_half = `DSOC_OSC_HP_7;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // configuration: straps until software writes; power-down wipes the
  // software copy, sleep does not touch it
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !power_down_bar_i) begin
      sw_written_reg <= 1'b0;
      sw_cfg_reg     <= '0;
    end else if (sw_cfg_wr_i) begin
      sw_written_reg <= 1'b1;
      sw_cfg_reg     <= sw_cfg_i;
    end
  end

  assign cfg = sw_written_reg ? sw_cfg_reg : strap_cfg_i;

  //////////////////////////////////////////////////////////////////////////
  // link state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      dsoc_pkg::DSOC_OFF: begin
        if (power_down_bar_i) begin
          state_next = dsoc_pkg::DSOC_ACQUIRE;
        end
      end
      dsoc_pkg::DSOC_ACQUIRE: begin
        if (!stream_present_i) begin
          state_next = dsoc_pkg::DSOC_SLEEP;
        end else if (acq_cnt_reg == ACQ_CYC - 10'h001) begin
          state_next = dsoc_pkg::DSOC_LOCKED;
        end
      end
      dsoc_pkg::DSOC_LOCKED: begin
        if (!stream_present_i) begin
          state_next = dsoc_pkg::DSOC_SLEEP;
        end
      end
      dsoc_pkg::DSOC_SLEEP: begin
        if (stream_present_i) begin
          state_next = dsoc_pkg::DSOC_ACQUIRE;
        end
      end
      default: state_next = dsoc_pkg::DSOC_OFF;
    endcase
    if (!power_down_bar_i) begin
      state_next = dsoc_pkg::DSOC_OFF;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_reg <= dsoc_pkg::DSOC_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i || state_reg != dsoc_pkg::DSOC_ACQUIRE) begin
      acq_cnt_reg <= 10'h000;
    end else begin
      acq_cnt_reg <= acq_cnt_reg + 10'h001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // spread modulation: tick marks each modulation period end
  assign mod_period = mod_div(cfg.spread_select_code, cfg.low_freq_range_select);

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      mod_cnt_reg  <= 16'h0000;
      mod_tick_o   <= 1'b0;
      mod_enable_o <= 1'b0;
      mod_dev_o    <= 4'h0;
    end else begin
      mod_enable_o <= (cfg.spread_select_code != `DSOC_SSC_OFF) &&
                      (state_reg == dsoc_pkg::DSOC_LOCKED);
      mod_dev_o    <= (cfg.spread_select_code == `DSOC_SSC_OFF) ? 4'h0 :
                      mod_step(cfg.spread_select_code);
      mod_tick_o   <= 1'b0;
      if (cfg.spread_select_code == `DSOC_SSC_OFF) begin
        mod_cnt_reg <= 16'h0000;
      end else if (mod_cnt_reg >= mod_period - 16'h0001) begin
        mod_cnt_reg <= 16'h0000;
        mod_tick_o  <= 1'b1;
      end else begin
        mod_cnt_reg <= mod_cnt_reg + 16'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // fallback oscillator
  assign osc_active = (cfg.oscillator_freq_select != `DSOC_OSC_OFF);

  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !osc_active) begin
      osc_cnt_reg <= 8'h00;
      osc_reg     <= 1'b0;
    end else if (osc_cnt_reg >= osc_half(cfg.oscillator_freq_select) - 8'h01) begin
      osc_cnt_reg <= 8'h00;
      osc_reg     <= ~osc_reg;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 8'h01;
    end
  end

  // source switches only when both clocks agree, so the output never glitches
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      clk_src_osc_reg <= 1'b0;
    end else if (osc_reg == rec_clk_i) begin
      clk_src_osc_reg <= osc_active && state_reg != dsoc_pkg::DSOC_LOCKED;
    end
  end

  assign clk_lvl = clk_src_osc_reg ? osc_reg : rec_clk_i;

  //////////////////////////////////////////////////////////////////////////
  // data path buffer: a stall downstream holds words instead of dropping them
  dsoc_buf u_buf (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .in_word_i   (rec_word_i),
    .in_valid_i  (buf_push),
    .in_ready_o  (buf_ready),
    .out_word_o  (buf_word),
    .out_valid_o (buf_valid),
    .out_ready_i (out_ready_i)
  );

  // ready is registered, so it must already promise room for the word taken
  // at the next edge; one word is held exactly when neither empty nor full
  assign buf_push      = rec_valid_i && rec_ready_o;
  assign buf_pop       = buf_valid && out_ready_i;
  assign rec_room_next = (state_next == dsoc_pkg::DSOC_LOCKED) &&
                         (buf_ready || buf_pop) &&
                         !(buf_valid && buf_ready && buf_push && !buf_pop);

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rec_ready_o <= 1'b0;
    end else begin
      rec_ready_o <= rec_room_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // output states
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      recovered_clock_out_o      <= 1'b0;
      recovered_clock_out_oe_b_o <= 1'b1;
      par_out_o                  <= '0;
      par_out_oe_b_o             <= 1'b1;
      par_valid_o                <= 1'b0;
      lock_o                     <= 1'b0;
      lock_oe_b_o                <= 1'b1;
      test_pass_o                <= 1'b0;
      test_pass_oe_b_o           <= 1'b1;
    end else begin
      par_valid_o <= 1'b0;
      case (state_next)
        dsoc_pkg::DSOC_OFF: begin
          recovered_clock_out_oe_b_o <= 1'b1;
          par_out_oe_b_o             <= 1'b1;
          lock_oe_b_o                <= 1'b1;
          test_pass_oe_b_o           <= 1'b1;
          lock_o                     <= 1'b0;
          test_pass_o                <= 1'b0;
          recovered_clock_out_o      <= 1'b0;
          par_out_o                  <= '0;
        end
        dsoc_pkg::DSOC_LOCKED: begin
          recovered_clock_out_o      <= clk_lvl;
          recovered_clock_out_oe_b_o <= 1'b0;
          par_out_oe_b_o             <= 1'b0;
          lock_o                     <= 1'b1;
          lock_oe_b_o                <= 1'b0;
          test_pass_o                <= 1'b1;
          test_pass_oe_b_o           <= 1'b0;
          if (buf_valid && out_ready_i) begin
            par_out_o   <= buf_word;
            par_valid_o <= 1'b1;
          end
        end
        default: begin
          lock_o      <= 1'b0;
          lock_oe_b_o <= 1'b0;
          par_out_o   <= '0;
          test_pass_oe_b_o <= 1'b0;
          if (osc_active) begin
            recovered_clock_out_o      <= clk_lvl;
            recovered_clock_out_oe_b_o <= 1'b0;
            par_out_oe_b_o             <= 1'b0;
            test_pass_o                <= 1'b1;
          end else if (cfg.output_state_select) begin
            recovered_clock_out_o      <= 1'b0;
            recovered_clock_out_oe_b_o <= 1'b1;
            par_out_oe_b_o             <= 1'b1;
            test_pass_o                <= 1'b0;
          end else begin
            recovered_clock_out_o      <= 1'b0;
            recovered_clock_out_oe_b_o <= 1'b0;
            par_out_oe_b_o             <= 1'b0;
            test_pass_o                <= 1'b0;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  sequence s_pd_low;
    !power_down_bar_i;
  endsequence

  pd_tristate_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_pd_low |=> lock_oe_b_o && par_out_oe_b_o && recovered_clock_out_oe_b_o
    && test_pass_oe_b_o) else $error("outputs not tri-stated in power-down");

  cfg_wipe_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_pd_low |=> !sw_written_reg) else $error("config survived power-down");

  sleep_keep_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (state_reg == dsoc_pkg::DSOC_SLEEP && power_down_bar_i && !sw_cfg_wr_i)
    |=> $stable(sw_cfg_reg)) else $error("config changed in sleep");

  acq_lock_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(power_down_bar_i) ##0 stream_present_i [*3] |=> !lock_o && !lock_oe_b_o)
    else $error("lock not low during acquisition");

  locked_out_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state_reg == dsoc_pkg::DSOC_LOCKED && stream_present_i && power_down_bar_i
    |=> lock_o && test_pass_o) else $error("locked outputs wrong");

  loss_lock_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state_reg == dsoc_pkg::DSOC_LOCKED && !stream_present_i |=> !lock_o)
    else $error("lock held after clock loss");

  sel_low_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state_reg == dsoc_pkg::DSOC_SLEEP && !stream_present_i && power_down_bar_i
    && !osc_active && !cfg.output_state_select
    |=> !recovered_clock_out_oe_b_o && !recovered_clock_out_o && !test_pass_o)
    else $error("static select-low outputs wrong");

  sel_high_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state_reg == dsoc_pkg::DSOC_SLEEP && !stream_present_i && power_down_bar_i
    && !osc_active && cfg.output_state_select
    |=> recovered_clock_out_oe_b_o && par_out_oe_b_o && !lock_oe_b_o)
    else $error("static select-high outputs wrong");

  osc_out_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state_reg == dsoc_pkg::DSOC_SLEEP && !stream_present_i && power_down_bar_i
    && osc_active |=> test_pass_o && !lock_o && par_out_o == '0)
    else $error("oscillator mode outputs wrong");

  spread_off_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cfg.spread_select_code == `DSOC_SSC_OFF |=> !mod_enable_o && mod_dev_o == 4'h0)
    else $error("spread active with code zero");
endmodule
`default_nettype wire

// File: dsoc_defs.svh
/*
  constants for the deserializer output-state control block: code fields,
  modulation divider counts, oscillator half periods and timing counts.
  assumes a 250 MHz system clock; included by bare name.
*/
`ifndef DSOC_DEFS_SVH
`define DSOC_DEFS_SVH
`define DSOC_SSC_W          4
`define DSOC_OSC_W          3
`define DSOC_DATA_W         27
`define DSOC_SSC_OFF        4'h0
`define DSOC_OSC_OFF        3'h0
// modulation periods in system-clock cycles, normal range
`define DSOC_MOD_HI_0       16'h0878
`define DSOC_MOD_HI_1       16'h0514
`define DSOC_MOD_HI_2       16'h0364
`define DSOC_MOD_HI_3       16'h028A
// low-frequency range
`define DSOC_MOD_LO_0       16'h026C
`define DSOC_MOD_LO_1       16'h0172
`define DSOC_MOD_LO_2       16'h0102
`define DSOC_MOD_LO_3       16'h00C0
// deviation steps in quarter percent: 0.5 1.0 1.5 2.0
`define DSOC_DEV_0          4'h2
`define DSOC_DEV_1          4'h4
`define DSOC_DEV_2          4'h6
`define DSOC_DEV_3          4'h8
// oscillator half periods at 250 MHz: 41.7,25,17.9,12.5,10.4,8.3,6.3 MHz
`define DSOC_OSC_HP_1       8'h03
`define DSOC_OSC_HP_2       8'h05
`define DSOC_OSC_HP_3       8'h07
`define DSOC_OSC_HP_4       8'h0A
`define DSOC_OSC_HP_5       8'h0C
`define DSOC_OSC_HP_6       8'h0F
`define DSOC_OSC_HP_7       8'h14
// relock acquisition time in ns and its derived cycle count
`define DSOC_ACQ_NS         400
`define DSOC_CLK_NS         4
`define DSOC_ACQ_CYC        ((`DSOC_ACQ_NS + `DSOC_CLK_NS - 1) / `DSOC_CLK_NS)
`endif

// File: dsoc_pkg.sv
/*
  types shared by the output-state control block and its buffer.
  assumes dsoc_defs.svh for widths.
*/
`default_nettype none
`include "dsoc_defs.svh"
package dsoc_pkg;
  typedef enum logic [2:0] {
    DSOC_OFF,
    DSOC_ACQUIRE,
    DSOC_LOCKED,
    DSOC_SLEEP
  } dsoc_state_e;

  typedef struct packed {
    logic [`DSOC_SSC_W-1:0] spread_select_code;
    logic                   low_freq_range_select;
    logic                   output_state_select;
    logic [`DSOC_OSC_W-1:0] oscillator_freq_select;
  } dsoc_cfg_s;

  typedef struct packed {
    logic [23:0] data;
    logic [2:0]  ctrl;
  } dsoc_word_s;
endpackage
`default_nettype wire

// File: dsoc_buf.sv
/*
  two-entry word buffer with valid/ready on both sides.
  assumes one clock and synchronous active-low reset.
*/
`default_nettype none
`include "dsoc_defs.svh"
module dsoc_buf (
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  input  wire dsoc_pkg::dsoc_word_s in_word_i,
  input  wire logic               in_valid_i,
  output logic                    in_ready_o,
  output dsoc_pkg::dsoc_word_s    out_word_o,
  output logic                    out_valid_o,
  input  wire logic               out_ready_i
);
  dsoc_pkg::dsoc_word_s mem_reg [2];
  logic                 wr_ptr_reg;
  logic                 rd_ptr_reg;
  logic [1:0]           count_reg;
  logic                 push;
  logic                 pop;

  assign in_ready_o  = (count_reg != 2'h2);
  assign out_valid_o = (count_reg != 2'h0);
  assign out_word_o  = mem_reg[rd_ptr_reg];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_word_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  // the writer must never offer a word that the buffer cannot take
  buf_no_overflow_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    in_valid_i |-> in_ready_o) else $error("word offered while buffer full");
endmodule
`default_nettype wire

// File: dsoc_ser_model.sv
/*
  stand-in for the serializer that feeds the recovered stream: embedded
  clock, stream-present flag and recovered words with valid/ready.
  assumes the bench calls send() and drives stream_on_i.
*/
`default_nettype none
module dsoc_ser_model (
  input  wire logic            clk_i,
  input  wire logic            stream_on_i,
  input  wire logic            rec_ready_i,
  output logic                 stream_present_o,
  output logic                 rec_clk_o,
  output dsoc_pkg::dsoc_word_s rec_word_o,
  output logic                 rec_valid_o,
  output logic                 stall_fail_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign stream_present_o = stream_on_i;
  initial begin
    rec_clk_o = 1'b0;
    rec_word_o = '0;
    rec_valid_o = 1'b0;
    stall_fail_o = 1'b0;
  end
  // embedded clock stands still while the stream is off
  always @(negedge clk_i) if (stream_on_i) rec_clk_o <= ~rec_clk_o;
  task automatic send(input dsoc_pkg::dsoc_word_s w);
    int n;
    n = 0;
    @(negedge clk_i);
    rec_word_o = w;
    rec_valid_o = 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (rec_ready_i !== 1'b1 && n < 300);
    if (n >= 300) stall_fail_o = 1'b1;
    @(negedge clk_i);
    rec_valid_o = 1'b0;
    // released lines must not keep showing the last word
    rec_word_o = ~w;
  endtask
endmodule
`default_nettype wire

// File: dsoc_ctrl_tb.sv
/*
  self-checking bench for the output-state control block: lock sequence,
  spread codes, buffer stall, sleep, output states, oscillator, power-down.
  assumes dsoc_ctrl, dsoc_pkg and the serializer stand-in are compiled.
*/
`default_nettype none
`include "dsoc_defs.svh"
module dsoc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk, rst_b, power_down_bar, s_on, s_pres, r_clk, r_val, r_rdy, sfail;
  logic                 sw_wr, o_rdy, rco, rco_oe_b, par_oe_b, p_val, lock, lock_oe_b;
  logic                 tp, tp_oe_b, mod_en, mod_tick;
  logic [3:0]           mod_dev;
  dsoc_pkg::dsoc_word_s r_word, par_out;
  dsoc_pkg::dsoc_cfg_s  strap, sw;
  dsoc_pkg::dsoc_word_s got[$];
  int                   err_count, checks_done, n;
  int                   hp[8] = '{0, `DSOC_OSC_HP_1, `DSOC_OSC_HP_2, `DSOC_OSC_HP_3,
                                  `DSOC_OSC_HP_4, `DSOC_OSC_HP_5, `DSOC_OSC_HP_6,
                                  `DSOC_OSC_HP_7};
  dsoc_ctrl i_dut (
    .clk_i(clk), .rst_b_i(rst_b), .power_down_bar_i(power_down_bar), .stream_present_i(s_pres),
    .rec_clk_i(r_clk), .rec_word_i(r_word), .rec_valid_i(r_val), .rec_ready_o(r_rdy),
    .strap_cfg_i(strap), .sw_cfg_i(sw), .sw_cfg_wr_i(sw_wr), .out_ready_i(o_rdy),
    .recovered_clock_out_o(rco), .recovered_clock_out_oe_b_o(rco_oe_b),
    .par_out_o(par_out), .par_out_oe_b_o(par_oe_b), .par_valid_o(p_val),
    .lock_o(lock), .lock_oe_b_o(lock_oe_b), .test_pass_o(tp), .test_pass_oe_b_o(tp_oe_b),
    .mod_enable_o(mod_en), .mod_dev_o(mod_dev), .mod_tick_o(mod_tick)
  );
  dsoc_ser_model i_ser (
    .clk_i(clk), .stream_on_i(s_on), .rec_ready_i(r_rdy), .stream_present_o(s_pres),
    .rec_clk_o(r_clk), .rec_word_o(r_word), .rec_valid_o(r_val), .stall_fail_o(sfail)
  );
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (p_val === 1'b1) got.push_back(par_out);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic dsoc_pkg::dsoc_cfg_s mk(input logic [3:0] c, input logic lf,
                                            input logic os, input logic [2:0] osc);
    mk = {c, lf, os, osc};
  endfunction
  task automatic chk(input bit ok, input string msg);
    checks_done++;
    if (!ok) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic timed_out(input string msg);
    chk(1'b0, msg);
    give_verdict();
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic wait_lock(output int k);
    k = 0;
    while (lock !== 1'b1) begin
      @(negedge clk);
      k++;
      if (k > 400) timed_out("no lock");
    end
  endtask
  task automatic set_sw(input dsoc_pkg::dsoc_cfg_s c);
    @(negedge clk);
    sw = c;
    sw_wr = 1'b1;
    @(negedge clk);
    sw_wr = 1'b0;
  endtask
  // cycles up to the next 0-to-1 step of the clock output
  task automatic next_rise(output int k);
    logic prev;
    k = 0;
    forever begin
      prev = rco;
      @(negedge clk);
      k++;
      if (rco === 1'b1 && prev === 1'b0) break;
      if (k > 200) timed_out("clock output idle");
    end
  endtask
  task automatic next_tick(input int lim, output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (mod_tick !== 1'b1 && k < lim);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    err_count = 0;
    checks_done = 0;
    rst_b = 1'b0;
    power_down_bar = 1'b0;
    s_on = 1'b0;
    strap = mk(4'h5, 1'b0, 1'b0, 3'h0);
    sw = mk(4'h0, 1'b0, 1'b0, 3'h0);
    sw_wr = 1'b0;
    o_rdy = 1'b1;
    cyc(8);
    rst_b = 1'b1;
    cyc(2);
    chk(rco_oe_b === 1'b1 && par_oe_b === 1'b1 && lock_oe_b === 1'b1, "driven in pd");
    chk(tp_oe_b === 1'b1, "result driven in pd");
    $display("test float done");
    s_on = 1'b1;
    power_down_bar = 1'b1;
    cyc(2);
    chk(lock_oe_b === 1'b0 && lock === 1'b0, "lock not low in acquire");
    wait_lock(n);
    // lock rises one cycle after the acquisition count; two cycles already waited
    chk(n == `DSOC_ACQ_CYC - 1, "acquisition length");
    chk(tp === 1'b1 && tp_oe_b === 1'b0 && rco_oe_b === 1'b0, "locked outputs");
    chk(par_oe_b === 1'b0, "data not driven");
    $display("test lock done");
    for (int lf = 0; lf < 2; lf++) begin
      for (int c = 0; c < 16; c++) begin
        strap = mk(4'(c), 1'(lf), 1'b0, 3'h0);
        cyc(3);
        chk(mod_en === (c != 0), "spread enable");
        if (c != 0) chk(mod_dev === 4'((((c - 1) % 4) + 1) * 2), "deviation");
      end
    end
    strap = mk(4'hD, 1'b1, 1'b0, 3'h0);
    next_tick(1000, n);
    next_tick(1000, n);
    chk(n == 192, "low range period");
    strap = mk(4'h1, 1'b0, 1'b0, 3'h0);
    next_tick(6000, n);
    next_tick(6000, n);
    chk(n == 2168, "normal range period");
    strap = mk(4'h0, 1'b0, 1'b0, 3'h0);
    cyc(2);
    next_tick(600, n);
    chk(n == 600, "tick with spread off");
    strap = mk(4'h5, 1'b0, 1'b0, 3'h0);
    $display("test spread done");
    o_rdy = 1'b0;
    fork
      for (int i = 0; i < 4; i++) i_ser.send(27'h123_4567 + 27'(i));
      begin
        cyc(40);
        chk(r_rdy === 1'b0 && got.size() == 0, "buffer not full");
        o_rdy = 1'b1;
      end
    join
    cyc(10);
    chk(got.size() == 4 && sfail === 1'b0, "word count");
    for (int i = 0; i < got.size(); i++) chk(got[i] === 27'h123_4567 + 27'(i), "word");
    $display("test buffer done");
    set_sw(mk(4'hA, 1'b0, 1'b0, 3'h0));
    cyc(3);
    chk(mod_dev === 4'h4, "software setting ignored");
    s_on = 1'b0;
    cyc(3);
    chk(lock === 1'b0 && lock_oe_b === 1'b0, "lock after loss");
    chk(rco === 1'b0 && rco_oe_b === 1'b0 && par_out === '0 && par_oe_b === 1'b0, "low");
    chk(tp === 1'b0 && tp_oe_b === 1'b0, "result low");
    s_on = 1'b1;
    wait_lock(n);
    chk(mod_dev === 4'h4, "setting lost in sleep");
    $display("test sleep done");
    set_sw(mk(4'hA, 1'b0, 1'b1, 3'h0));
    s_on = 1'b0;
    cyc(3);
    chk(rco_oe_b === 1'b1 && par_oe_b === 1'b1, "clock/data not floating");
    chk(lock === 1'b0 && lock_oe_b === 1'b0 && tp === 1'b0 && tp_oe_b === 1'b0, "st");
    $display("test state select done");
    for (int o = 1; o < 8; o++) begin
      set_sw(mk(4'hA, 1'b0, 1'b0, 3'(o)));
      next_rise(n);
      next_rise(n);
      chk(n == 2 * hp[o], "oscillator period");
      chk(rco_oe_b === 1'b0 && tp === 1'b1 && lock === 1'b0 && par_out === '0, "osc");
    end
    s_on = 1'b1;
    wait_lock(n);
    chk(rco_oe_b === 1'b0, "clock released at changeover");
    $display("test oscillator done");
    power_down_bar = 1'b0;
    cyc(3);
    chk(rco_oe_b === 1'b1 && par_oe_b === 1'b1 && lock_oe_b === 1'b1, "pd float");
    power_down_bar = 1'b1;
    wait_lock(n);
    chk(mod_dev === 4'h2, "software setting kept over power-down");
    $display("test power-down done");
    give_verdict();
  end
endmodule
`default_nettype wire
